// [src/dual_timer_pkg.sv]
// constants shared by the dual timer/counter block
// assumes a 32-bit apb slave and one system clock
package dual_timer_pkg;

  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;

  // register byte addresses
  localparam logic [APB_ADDR_W-1:0] ADDR_CONTROL = 8'h00;
  localparam logic [APB_ADDR_W-1:0] ADDR_MODE = 8'h04;
  localparam logic [APB_ADDR_W-1:0] ADDR_T0_LOW = 8'h08;
  localparam logic [APB_ADDR_W-1:0] ADDR_T0_HIGH = 8'h0C;
  localparam logic [APB_ADDR_W-1:0] ADDR_T1_LOW = 8'h10;
  localparam logic [APB_ADDR_W-1:0] ADDR_T1_HIGH = 8'h14;

  // timer_control bit positions
  localparam int CTL_T1_OVF = 7;
  localparam int CTL_T1_RUN = 6;
  localparam int CTL_T0_OVF = 5;
  localparam int CTL_T0_RUN = 4;
  localparam int CTL_X1_EDGE = 3;
  localparam int CTL_X1_TYPE = 2;
  localparam int CTL_X0_EDGE = 1;
  localparam int CTL_X0_TYPE = 0;

  // timer_mode nibble base and field offsets
  localparam int MODE_T1_LSB = 4;
  localparam int MODE_T0_LSB = 0;
  localparam int FLD_GATE = 3;
  localparam int FLD_FUNC = 2;
  localparam int FLD_MODE_HI = 1;
  localparam int FLD_MODE_LO = 0;

  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_t;

  // machine cycle timing, in cpu clocks
  localparam int MC_PHASES = 6;
  localparam int PHASE_W = 3;
  localparam logic [PHASE_W-1:0] SAMPLE_PHASE = 3'h4;
  localparam logic [PHASE_W-1:0] UPDATE_PHASE = 3'h2;

  localparam int PRESCALE_W = 5;
  localparam logic [7:0] RESET_BYTE = 8'h00;

endpackage

// [src/mc_phase_gen.sv]
// machine cycle phase generator: one-cycle sample and update strobes
// assumes sys_clk is the cpu clock
`timescale 1ns/1ps
module mc_phase_gen
  import dual_timer_pkg::*;
#(
  parameter int PHASES = MC_PHASES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  output logic sample_point,
  output logic update_point
);

  typedef struct packed {
    logic [PHASE_W-1:0] phase;
    logic sample;
    logic update;
  } phase_state_t;

  phase_state_t q;
  phase_state_t d;

  always_comb begin
    d = q;
    if (q.phase == PHASE_W'(PHASES - 1)) begin
      d.phase = '0;
    end else begin
      d.phase = q.phase + PHASE_W'(1);
    end
    // strobes are high during the matching phase
    d.sample = (d.phase == SAMPLE_PHASE);
    d.update = (d.phase == UPDATE_PHASE);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sample_point = q.sample;
  assign update_point = q.update;

endmodule

// [src/fall_sampler.sv]
// samples a pin once per machine cycle and flags a high-to-low step
// assumes the pin is synchronous to sys_clk
`timescale 1ns/1ps
module fall_sampler (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic sample_point,
  input wire logic pin,
  output logic level,
  output logic fell
);

  typedef struct packed {
    logic prev;
    logic fell;
  } sampler_state_t;

  sampler_state_t q;
  sampler_state_t d;

  always_comb begin
    d = q;
    if (sample_point) begin
      // fell stays up for one whole machine cycle
      d.fell = q.prev & ~pin;
      d.prev = pin;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // prev starts at the idle high level: no false low level or edge after reset
      q <= '{prev: 1'b1, fell: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign level = q.prev;
  assign fell = q.fell;

endmodule

// [src/dual_timer_counter.sv]
// two timer/counters with mode, control and count registers on apb
// assumes synchronous pins and vector acks from the interrupt logic
`timescale 1ns/1ps
module dual_timer_counter
  import dual_timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [APB_DATA_W-1:0] pwdata,
  output logic [APB_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic t0_count_pin,
  input wire logic t1_count_pin,
  input wire logic xint0_pin,
  input wire logic xint1_pin,
  input wire logic t0_vector_ack,
  input wire logic t1_vector_ack,
  input wire logic xint0_vector_ack,
  input wire logic xint1_vector_ack,
  output logic t0_overflow_flag,
  output logic t1_overflow_flag,
  output logic xint0_edge_flag,
  output logic xint1_edge_flag
);

  typedef struct packed {
    logic [7:0] timer_control;
    logic [7:0] timer_mode;
    logic [7:0] t0_high_byte;
    logic [7:0] t0_low_byte;
    logic [7:0] t1_high_byte;
    logic [7:0] t1_low_byte;
    logic [APB_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } timer_state_t;

  timer_state_t q;
  timer_state_t d;

  // one step of a counter pair: {overflow, high, low}
  function automatic logic [16:0] count_step(input timer_mode_t mode,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
    logic [8:0] lo_sum;
    logic [8:0] hi_sum;
    logic [PRESCALE_W:0] pre;
    lo_sum = {1'b0, lo} + 9'h001;
    pre = {1'b0, lo[PRESCALE_W-1:0]} + 6'h01;
    hi_sum = '0;
    case (mode)
      MODE_13BIT: begin
        hi_sum = {1'b0, hi} + {8'h00, pre[PRESCALE_W]};
        count_step = {hi_sum[8], hi_sum[7:0], lo[7:PRESCALE_W],
                      pre[PRESCALE_W-1:0]};
      end
      MODE_16BIT: begin
        hi_sum = {1'b0, hi} + {8'h00, lo_sum[8]};
        count_step = {hi_sum[8], hi_sum[7:0], lo_sum[7:0]};
      end
      MODE_RELOAD: begin
        count_step = {lo_sum[8], hi, lo_sum[8] ? hi : lo_sum[7:0]};
      end
      default: begin
        count_step = {lo_sum[8], hi, lo_sum[7:0]};
      end
    endcase
  endfunction

  // apb decode, used only for the error reply of reads and writes
  function automatic logic addr_mapped(input logic [APB_ADDR_W-1:0] a);
    addr_mapped = (a == ADDR_CONTROL) || (a == ADDR_MODE) ||
                  (a == ADDR_T0_LOW) || (a == ADDR_T0_HIGH) ||
                  (a == ADDR_T1_LOW) || (a == ADDR_T1_HIGH);
  endfunction

  logic sample_point;
  logic update_point;
  logic t0_pin_fell;
  logic t1_pin_fell;
  logic xint0_level;
  logic xint0_fell;
  logic xint1_level;
  logic xint1_fell;

  mc_phase_gen #(
    .PHASES(MC_PHASES)
  ) u_phase (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sample_point(sample_point),
    .update_point(update_point)
  );

  fall_sampler u_t0_pin (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sample_point(sample_point),
    .pin(t0_count_pin),
    .level(),
    .fell(t0_pin_fell)
  );

  fall_sampler u_t1_pin (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sample_point(sample_point),
    .pin(t1_count_pin),
    .level(),
    .fell(t1_pin_fell)
  );

  fall_sampler u_x0_pin (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sample_point(sample_point),
    .pin(xint0_pin),
    .level(xint0_level),
    .fell(xint0_fell)
  );

  fall_sampler u_x1_pin (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .sample_point(sample_point),
    .pin(xint1_pin),
    .level(xint1_level),
    .fell(xint1_fell)
  );

  // mode register fields
  timer_mode_t t0_mode;
  timer_mode_t t1_mode;
  logic t0_gate;
  logic t1_gate;
  logic t0_func;
  logic t1_func;
  logic t0_run_bit;
  logic t1_run_bit;
  logic t0_split;

  assign t0_mode = timer_mode_t'({q.timer_mode[MODE_T0_LSB+FLD_MODE_HI],
                                  q.timer_mode[MODE_T0_LSB+FLD_MODE_LO]});
  assign t1_mode = timer_mode_t'({q.timer_mode[MODE_T1_LSB+FLD_MODE_HI],
                                  q.timer_mode[MODE_T1_LSB+FLD_MODE_LO]});
  assign t0_gate = q.timer_mode[MODE_T0_LSB+FLD_GATE];
  assign t1_gate = q.timer_mode[MODE_T1_LSB+FLD_GATE];
  assign t0_func = q.timer_mode[MODE_T0_LSB+FLD_FUNC];
  assign t1_func = q.timer_mode[MODE_T1_LSB+FLD_FUNC];
  assign t0_run_bit = q.timer_control[CTL_T0_RUN];
  assign t1_run_bit = q.timer_control[CTL_T1_RUN];
  assign t0_split = (t0_mode == MODE_SPLIT);

  // count enables and ticks
  logic t0_enable;
  logic t1_enable;
  logic t0_tick;
  logic t1_tick;
  logic th0_tick;
  logic [16:0] t0_next;
  logic [16:0] t1_next;
  logic [8:0] th0_next;
  logic t0_ovf_set;
  logic t1_ovf_set;
  logic x0_set;
  logic x1_set;

  assign t0_enable = t0_run_bit & (~t0_gate | xint0_pin);
  // with timer 0 split, timer 1 loses its run bit and runs unless in mode 3
  assign t1_enable = (t1_mode != MODE_SPLIT) &
                     (t0_split | (t1_run_bit & (~t1_gate | xint1_pin)));
  assign t0_tick = update_point & t0_enable & (t0_func ? t0_pin_fell : 1'b1);
  assign t1_tick = update_point & t1_enable & (t1_func ? t1_pin_fell : 1'b1);
  assign th0_tick = update_point & t0_split & t1_run_bit;
  assign t0_next = count_step(t0_mode, q.t0_high_byte, q.t0_low_byte);
  assign t1_next = count_step(t1_mode, q.t1_high_byte, q.t1_low_byte);
  assign th0_next = {1'b0, q.t0_high_byte} + 9'h001;

  assign t0_ovf_set = t0_tick & t0_next[16];
  assign t1_ovf_set = t0_split ? (th0_tick & th0_next[8])
                               : (t1_tick & t1_next[16]);
  assign x0_set = update_point &
                  (q.timer_control[CTL_X0_TYPE] ? xint0_fell : ~xint0_level);
  assign x1_set = update_point &
                  (q.timer_control[CTL_X1_TYPE] ? xint1_fell : ~xint1_level);

  logic apb_setup;
  logic apb_write;

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite & q.pready;

  always_comb begin
    d = q;
    d.pready = 1'b0;
    d.pslverr = 1'b0;

    // counting
    if (t0_tick) begin
      d.t0_low_byte = t0_next[7:0];
      if (!t0_split) begin
        d.t0_high_byte = t0_next[15:8];
      end
    end
    if (th0_tick) begin
      d.t0_high_byte = th0_next[7:0];
    end
    if (t1_tick) begin
      d.t1_low_byte = t1_next[7:0];
      d.t1_high_byte = t1_next[15:8];
    end

    // software writes win over a count in the same cycle
    if (apb_write) begin
      case (paddr)
        ADDR_CONTROL: d.timer_control = pwdata[7:0];
        ADDR_MODE: d.timer_mode = pwdata[7:0];
        ADDR_T0_LOW: d.t0_low_byte = pwdata[7:0];
        ADDR_T0_HIGH: d.t0_high_byte = pwdata[7:0];
        ADDR_T1_LOW: d.t1_low_byte = pwdata[7:0];
        ADDR_T1_HIGH: d.t1_high_byte = pwdata[7:0];
        default: d.pslverr = 1'b0;
      endcase
    end

    // vector acks clear, hardware sets win over any clear
    if (t0_vector_ack) begin
      d.timer_control[CTL_T0_OVF] = 1'b0;
    end
    if (t1_vector_ack) begin
      d.timer_control[CTL_T1_OVF] = 1'b0;
    end
    if (xint0_vector_ack) begin
      d.timer_control[CTL_X0_EDGE] = 1'b0;
    end
    if (xint1_vector_ack) begin
      d.timer_control[CTL_X1_EDGE] = 1'b0;
    end
    if (t0_ovf_set) begin
      d.timer_control[CTL_T0_OVF] = 1'b1;
    end
    if (t1_ovf_set) begin
      d.timer_control[CTL_T1_OVF] = 1'b1;
    end
    if (x0_set) begin
      d.timer_control[CTL_X0_EDGE] = 1'b1;
    end
    if (x1_set) begin
      d.timer_control[CTL_X1_EDGE] = 1'b1;
    end

    // read data captured in setup, presented in access with no wait state
    if (apb_setup) begin
      d.pready = 1'b1;
      d.pslverr = ~addr_mapped(paddr);
      case (paddr)
        ADDR_CONTROL: d.prdata = {24'h000000, q.timer_control};
        ADDR_MODE: d.prdata = {24'h000000, q.timer_mode};
        ADDR_T0_LOW: d.prdata = {24'h000000, q.t0_low_byte};
        ADDR_T0_HIGH: d.prdata = {24'h000000, q.t0_high_byte};
        ADDR_T1_LOW: d.prdata = {24'h000000, q.t1_low_byte};
        ADDR_T1_HIGH: d.prdata = {24'h000000, q.t1_high_byte};
        default: d.prdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      q.timer_control <= RESET_BYTE;
      q.timer_mode <= RESET_BYTE;
      q.t0_high_byte <= RESET_BYTE;
      q.t0_low_byte <= RESET_BYTE;
      q.t1_high_byte <= RESET_BYTE;
      q.t1_low_byte <= RESET_BYTE;
      q.prdata <= '0;
      q.pready <= 1'b0;
      q.pslverr <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign t0_overflow_flag = q.timer_control[CTL_T0_OVF];
  assign t1_overflow_flag = q.timer_control[CTL_T1_OVF];
  assign xint0_edge_flag = q.timer_control[CTL_X0_EDGE];
  assign xint1_edge_flag = q.timer_control[CTL_X1_EDGE];

endmodule

// [verif/dual_timer_monitor.sv]
// checker for the apb side and status flags of the dual timer block
// assumes it is bound to dual_timer_counter and sees only its ports
`timescale 1ns/1ps
module dual_timer_monitor
  import dual_timer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic t0_vector_ack,
  input wire logic t1_vector_ack,
  input wire logic xint0_vector_ack,
  input wire logic xint1_vector_ack,
  input wire logic t0_overflow_flag,
  input wire logic t1_overflow_flag,
  input wire logic xint0_edge_flag,
  input wire logic xint1_edge_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic wr;
  assign wr = psel & penable & pwrite;
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_refused_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read data not zero");
  a_t0_flag_clear: assert property ($fell(t0_overflow_flag) |-> $past(t0_vector_ack) || $past(wr))
    else $error("t0 flag dropped without cause");
  a_t1_flag_clear: assert property ($fell(t1_overflow_flag) |-> $past(t1_vector_ack) || $past(wr))
    else $error("t1 flag dropped without cause");
  a_x0_flag_clear: assert property ($fell(xint0_edge_flag) |-> $past(xint0_vector_ack) || $past(wr))
    else $error("xint0 flag dropped without cause");
  a_x1_flag_clear: assert property ($fell(xint1_edge_flag) |-> $past(xint1_vector_ack) || $past(wr))
    else $error("xint1 flag dropped without cause");
  c_refused: cover property (pready && pslverr);
  c_t0_overflow: cover property ($rose(t0_overflow_flag));
  c_t1_overflow: cover property ($rose(t1_overflow_flag));
  c_x1_edge: cover property ($rose(xint1_edge_flag));
endmodule

bind dual_timer_counter dual_timer_monitor u_mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .t0_vector_ack(t0_vector_ack), .t1_vector_ack(t1_vector_ack),
  .xint0_vector_ack(xint0_vector_ack), .xint1_vector_ack(xint1_vector_ack),
  .t0_overflow_flag(t0_overflow_flag), .t1_overflow_flag(t1_overflow_flag),
  .xint0_edge_flag(xint0_edge_flag), .xint1_edge_flag(xint1_edge_flag));

// [verif/pin_source.sv]
// external pin source: falling edges on a count or interrupt pin
// assumes go is a one-cycle pulse synchronous to sys_clk
`timescale 1ns/1ps
module pin_source #(
  parameter int HOLD = 12
) (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [7:0] pulses,
  output logic pin,
  output logic busy
);
  int cnt = 0;
  int left = 0;
  initial pin = 1'b1;
  initial busy = 1'b0;
  // idle high, each level held two machine cycles
  always @(posedge sys_clk) begin
    if (!busy && go) begin
      busy <= 1'b1;
      left <= 2 * pulses;
      cnt <= HOLD;
    end else if (busy && cnt > 1) begin
      cnt <= cnt - 1;
    end else if (busy) begin
      pin <= ~pin;
      cnt <= HOLD;
      left <= left - 1;
      busy <= (left > 1);
    end
  end
endmodule

// [verif/tb_dual_timer_counter.sv]
// self-checking bench for the dual timer/counter block
// assumes apb answers after setup and pins change on clock edges
`timescale 1ns/1ps
module tb_dual_timer_counter;
  import dual_timer_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [31:0] q; logic e;} row_t;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_ADDR_W-1:0] paddr = '0;
  logic [APB_DATA_W-1:0] pwdata = '0;
  logic [APB_DATA_W-1:0] prdata, rd;
  logic pready, pslverr, err, t1_count_pin, xint1_pin, cnt_busy, x1_busy;
  logic t0_count_pin = 1'b0, xint0_pin = 1'b1, cnt_go = 1'b0, x1_go = 1'b0;
  logic [3:0] ack_v = 4'h0;
  logic [3:0] fl;
  logic [5:0] flags;
  int err_total = 0, tests_run = 0, c;
  row_t rows [7];
  always #12.5 sys_clk = ~sys_clk;
  assign flags = {x1_busy, cnt_busy, fl};
  dual_timer_counter i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .t0_count_pin(t0_count_pin),
    .t1_count_pin(t1_count_pin), .xint0_pin(xint0_pin), .xint1_pin(xint1_pin),
    .t0_vector_ack(ack_v[0]), .t1_vector_ack(ack_v[1]), .xint0_vector_ack(ack_v[2]),
    .xint1_vector_ack(ack_v[3]), .t0_overflow_flag(fl[0]), .t1_overflow_flag(fl[1]),
    .xint0_edge_flag(fl[2]), .xint1_edge_flag(fl[3]));
  pin_source u_cnt (.sys_clk(sys_clk), .go(cnt_go), .pulses(8'h05), .pin(t1_count_pin),
    .busy(cnt_busy));
  pin_source u_x1 (.sys_clk(sys_clk), .go(x1_go), .pulses(8'h01), .pin(xint1_pin),
    .busy(x1_busy));

  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_total++;
        report_and_stop();
      end
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, exp});
  endtask
  task automatic wait_bit(input int s, input logic v, input int lim);
    c = 0;
    while (flags[s] !== v) begin
      c++;
      if (c > lim) begin
        err_total++;
        report_and_stop();
      end
      @(posedge sys_clk);
    end
  endtask
  task automatic ack(input int s);
    ack_v[s] <= 1'b1;
    @(posedge sys_clk);
    ack_v[s] <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic go_pin(input logic x1);
    if (x1) x1_go <= 1'b1;
    else cnt_go <= 1'b1;
    @(posedge sys_clk);
    x1_go <= 1'b0;
    cnt_go <= 1'b0;
    @(posedge sys_clk);
  endtask

  initial begin
    rows = '{'{ADDR_MODE, 8'hA5, 32'hA5, 1'b0}, '{ADDR_T0_LOW, 8'h3C, 32'h3C, 1'b0},
      '{ADDR_T0_HIGH, 8'hC3, 32'hC3, 1'b0}, '{ADDR_T1_LOW, 8'h5A, 32'h5A, 1'b0},
      '{ADDR_T1_HIGH, 8'h7E, 32'h7E, 1'b0}, '{ADDR_CONTROL, 8'h05, 32'h05, 1'b0},
      '{8'h18, 8'h77, 32'h0, 1'b1}};
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      chk({31'h0, err}, {31'h0, rows[i].e});
      apb(1'b0, rows[i].a, 8'h00);
      chk(rd, rows[i].q);
      chk({31'h0, err}, {31'h0, rows[i].e});
    end
    // mode 0: prescaler carries into high byte, then rolls over
    apb(1'b1, ADDR_MODE, 8'h00);
    apb(1'b1, ADDR_T0_HIGH, 8'hFF);
    apb(1'b1, ADDR_T0_LOW, 8'h1F);
    apb(1'b1, ADDR_CONTROL, 8'h10);
    wait_bit(0, 1'b1, 20);
    apb(1'b1, ADDR_CONTROL, 8'h00);
    rreg(ADDR_T0_HIGH, 8'h00);
    rreg(ADDR_T0_LOW, 8'h00);
    // mode 1: low byte carries into high byte, all sixteen bits roll over
    apb(1'b1, ADDR_MODE, 8'h01);
    apb(1'b1, ADDR_T0_HIGH, 8'hFF);
    apb(1'b1, ADDR_T0_LOW, 8'hFF);
    apb(1'b1, ADDR_CONTROL, 8'h10);
    wait_bit(0, 1'b1, 20);
    apb(1'b1, ADDR_CONTROL, 8'h00);
    rreg(ADDR_T0_HIGH, 8'h00);
    rreg(ADDR_T0_LOW, 8'h00);
    // mode 2: reload period of ten machine cycles
    apb(1'b1, ADDR_MODE, 8'h02);
    apb(1'b1, ADDR_T0_HIGH, 8'hF6);
    apb(1'b1, ADDR_T0_LOW, 8'hF6);
    apb(1'b1, ADDR_CONTROL, 8'h10);
    wait_bit(0, 1'b1, 80);
    ack(0);
    wait_bit(0, 1'b1, 80);
    chk(32'(c + 2), 32'd60);
    rreg(ADDR_T0_HIGH, 8'hF6);
    // gated t0 held, t1 counts pin edges
    apb(1'b1, ADDR_CONTROL, 8'h00);
    apb(1'b1, ADDR_T0_LOW, 8'h20);
    apb(1'b1, ADDR_T1_LOW, 8'h00);
    apb(1'b1, ADDR_MODE, 8'h59);
    xint0_pin <= 1'b0;
    apb(1'b1, ADDR_CONTROL, 8'h50);
    go_pin(1'b0);
    wait_bit(4, 1'b0, 200);
    repeat (12) @(posedge sys_clk);
    rreg(ADDR_T1_LOW, 8'h05);
    rreg(ADDR_T0_LOW, 8'h20);
    chk({31'h0, fl[2]}, 32'h1);
    xint0_pin <= 1'b1;
    repeat (30) @(posedge sys_clk);
    apb(1'b0, ADDR_T0_LOW, 8'h00);
    chk({31'h0, rd[7:0] > 8'h20}, 32'h1);
    ack(2);
    chk({31'h0, fl[2]}, 32'h0);
    // edge-triggered interrupt 1
    apb(1'b1, ADDR_CONTROL, 8'h04);
    go_pin(1'b1);
    wait_bit(3, 1'b1, 100);
    ack(3);
    chk({31'h0, fl[3]}, 32'h0);
    // split t0, t1 stopped in its own mode 3
    apb(1'b1, ADDR_T0_HIGH, 8'hFF);
    apb(1'b1, ADDR_T1_LOW, 8'h44);
    apb(1'b1, ADDR_MODE, 8'h33);
    apb(1'b1, ADDR_CONTROL, 8'h40);
    wait_bit(1, 1'b1, 20);
    chk({31'h0, fl[0]}, 32'h0);
    repeat (30) @(posedge sys_clk);
    rreg(ADDR_T1_LOW, 8'h44);
    ack(1);
    // reset in mid-run
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rreg(ADDR_CONTROL, 8'h00);
    rreg(ADDR_MODE, 8'h00);
    chk({28'h0, fl}, 32'h0);
    report_and_stop();
  end
endmodule
